// File: gtc_pkg.sv
// Constants for the global test-control and dither block
//
// Summary of operation
// - Registers decode when the top five address bits match the global pattern; chip-wide.
// - Override bit 16 drives control bits 31 to 17 onto the output pins.
// - Pin override acts only while test mode bit 0 is also set.
// - Bit 31 interrupt, 30 sync out, 29 serial clock, then sync, first, second lines.
// - Bit 29 overrides the serial clock only while a divided clock is selected.
// - Bits 7 to 4 put channel sine MSB on second serial line; 7 is channel zero.
// - A pseudo-noise dither is provided for every channel mixer.
// - Bit 2 enables the 23-stage generator; cleared it contributes nothing.
// - Bit 1 enables the 15-stage generator; cleared it contributes nothing.
// - Both generator outputs are exclusive-ORed; each may be disabled on its own.
// - With bit 3 set, I dither is also exclusive-ORed with 23-stage bit 10.
// - With bit 3 clear, I and Q get the same dither.
// - Bit 0 places the device in internal self-test mode.
package gtc_pkg;
   localparam int          ADDR_W            = 16;
   localparam int          DATA_W            = 32;
   localparam int          NUM_CH            = 4;
   localparam int          GLOBAL_HI_W       = 5;
   localparam logic [4:0]  GLOBAL_PATTERN    = 5'h1F;
   localparam logic [15:0] ADDR_TEST_CTL     = 16'hF800;
   localparam logic [15:0] ADDR_CTL_READBACK = 16'hF810;
   localparam logic [15:0] ADDR_PN23_STAT    = 16'hF811;
   localparam logic [15:0] ADDR_PN15_STAT    = 16'hF812;
   localparam logic [31:0] CTL_RESET         = 32'h0000_0000;
   localparam logic [31:0] CTL_WRITE_MASK    = 32'hFFFF_03FF;
   localparam int          BIT_TEST_MODE     = 0;
   localparam int          BIT_PN15_EN       = 1;
   localparam int          BIT_PN23_EN       = 2;
   localparam int          BIT_I_OFFSET      = 3;
   localparam int          BIT_SINE_HI       = 7;
   localparam int          BIT_OVR_EN        = 16;
   localparam int          BIT_SD2_HI        = 20;
   localparam int          BIT_SD1_HI        = 24;
   localparam int          BIT_SYNC_HI       = 28;
   localparam int          BIT_SERIAL_OUT_CLOCK        = 29;
   localparam int          BIT_SYNC_OUT      = 30;
   localparam int          BIT_INTR          = 31;
   localparam int          PN23_W            = 23;
   localparam int          PN23_TAP          = 18;
   localparam int          PN23_I_BIT        = 10;
   localparam logic [22:0] PN23_SEED         = 23'h000001;
   localparam int          PN15_W            = 15;
   localparam int          PN15_TAP          = 14;
   localparam logic [14:0] PN15_SEED         = 15'h0001;
endpackage

// File: gtc_pn_if.sv
// Carrier between the control block and one pseudo-noise generator
`timescale 1ns/1ps
`default_nettype none
interface gtc_pn_if #(parameter int WIDTH = 23);
   logic             enable;
   logic [WIDTH-1:0] state;
   logic             pn_bit;
   modport gen  (input enable, output state, output pn_bit);
   modport user (output enable, input state, input pn_bit);
endinterface
`default_nettype wire

// File: gtc_pn_lfsr.sv
// Maximal-length Fibonacci pseudo-noise generator
`timescale 1ns/1ps
`default_nettype none
module gtc_pn_lfsr #(
   parameter int             WIDTH = 23,
   parameter int             TAP   = 18,
   parameter logic [WIDTH-1:0] SEED = '1
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   gtc_pn_if.gen     pn
);
   logic [WIDTH-1:0] lfsr_q;
   logic [WIDTH-1:0] lfsr_d;
   logic             feedback;

   // Taps at WIDTH and TAP give a maximal-length sequence
   assign feedback = lfsr_q[WIDTH-1] ^ lfsr_q[TAP-1];
   assign lfsr_d   = pn.enable ? {lfsr_q[WIDTH-2:0], feedback} : lfsr_q;
   // Disabled generator contributes nothing
   assign pn.pn_bit = pn.enable & lfsr_q[WIDTH-1];
   assign pn.state  = lfsr_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lfsr_q <= SEED;
      end else begin
         lfsr_q <= lfsr_d;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_state_never_zero: assert property (lfsr_q != '0)
      else $error("pn generator reached the all-zero lock-up state");
   // Output is judged in the disabled cycle itself; the enable may rise in the next one
   a_disabled_holds: assert property (!pn.enable |-> !pn.pn_bit ##1 $stable(lfsr_q))
      else $error("disabled pn generator moved or produced output");
   a_enabled_shifts: assert property (pn.enable |=> lfsr_q[WIDTH-1:1] == $past(lfsr_q[WIDTH-2:0]))
      else $error("enabled pn generator did not shift");
endmodule
`default_nettype wire

// File: gtc_test_ctrl.sv
// Global test-control register, pin override, sine routing and dither generation
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module gtc_test_ctrl
   import gtc_pkg::*;
(
   input  wire logic              clk_sys_in,
   input  wire logic              rst_n_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   input  wire logic              serial_out_clock_divided_in,
   input  wire logic              intr_fn_in,
   input  wire logic              sync_out_fn_in,
   input  wire logic              serial_out_clock_fn_in,
   input  wire logic [NUM_CH-1:0] chan_sync_fn_in,
   input  wire logic [NUM_CH-1:0] first_serial_fn_in,
   input  wire logic [NUM_CH-1:0] second_serial_fn_in,
   input  wire logic [NUM_CH-1:0] carrier_sine_msb_in,
   output logic                   intr_pin_out,
   output logic                   sync_out_pin_out,
   output logic                   serial_out_clock_out,
   output logic      [NUM_CH-1:0] chan_sync_pin_out,
   output logic      [NUM_CH-1:0] first_serial_line_out,
   output logic      [NUM_CH-1:0] second_serial_line_out,
   output logic                   self_test_mode_out,
   output logic                   dither_i_out,
   output logic                   dither_q_out
);
   // Reset release synchroniser
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Global address window decode
   function automatic logic in_global_space(input logic [ADDR_W-1:0] addr);
      in_global_space = (addr[ADDR_W-1 -: GLOBAL_HI_W] == GLOBAL_PATTERN);
   endfunction

   logic              global_hit;
   logic              sel_test_ctl;
   logic              sel_readback;
   logic              sel_pn23;
   logic              sel_pn15;
   logic              wr_test_ctl;
   logic [DATA_W-1:0] ctl_q;
   logic [DATA_W-1:0] ctl_d;

   assign global_hit   = in_global_space(reg_addr_in);
   assign sel_test_ctl = global_hit && (reg_addr_in == ADDR_TEST_CTL);
   assign sel_readback = global_hit && (reg_addr_in == ADDR_CTL_READBACK);
   assign sel_pn23     = global_hit && (reg_addr_in == ADDR_PN23_STAT);
   assign sel_pn15     = global_hit && (reg_addr_in == ADDR_PN15_STAT);
   assign wr_test_ctl  = reg_wr_in && sel_test_ctl;
   // Unused bits 15:10 are dropped so stray writes cannot reach any logic
   assign ctl_d = wr_test_ctl ? (reg_wdata_in & CTL_WRITE_MASK) : ctl_q;

   always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         ctl_q <= CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // Control field decode
   logic test_mode;
   logic override_on;
   logic pn23_en;
   logic pn15_en;
   logic i_offset_en;

   assign test_mode   = ctl_q[BIT_TEST_MODE];
   assign override_on = ctl_q[BIT_OVR_EN] & test_mode;
   assign pn23_en     = ctl_q[BIT_PN23_EN];
   assign pn15_en     = ctl_q[BIT_PN15_EN];
   assign i_offset_en = ctl_q[BIT_I_OFFSET];

   // Pseudo-noise generators
   gtc_pn_if #(.WIDTH(PN23_W)) pn23_if ();
   gtc_pn_if #(.WIDTH(PN15_W)) pn15_if ();

   assign pn23_if.enable = pn23_en;
   assign pn15_if.enable = pn15_en;

   gtc_pn_lfsr #(
      .WIDTH (PN23_W),
      .TAP   (PN23_TAP),
      .SEED  (PN23_SEED)
   ) u_pn23 (
      .clk_in   (clk_sys_in),
      .rst_n_in (rst_sync_q),
      .pn       (pn23_if)
   );

   gtc_pn_lfsr #(
      .WIDTH (PN15_W),
      .TAP   (PN15_TAP),
      .SEED  (PN15_SEED)
   ) u_pn15 (
      .clk_in   (clk_sys_in),
      .rst_n_in (rst_sync_q),
      .pn       (pn15_if)
   );

   // Dither combine
   logic dither_comb;
   logic i_decorr_bit;
   logic dither_i_d;

   assign dither_comb  = pn23_if.pn_bit ^ pn15_if.pn_bit;
   // The delayed tap is gated with the enable so a disabled generator adds nothing
   assign i_decorr_bit = pn23_en & pn23_if.state[PN23_I_BIT];
   assign dither_i_d   = i_offset_en ? (dither_comb ^ i_decorr_bit) : dither_comb;

   // Pin override and sine routing
   logic              intr_d;
   logic              sync_out_d;
   logic              serial_out_clock_d;
   logic [NUM_CH-1:0] chan_sync_d;
   logic [NUM_CH-1:0] first_serial_d;
   logic [NUM_CH-1:0] second_serial_d;

   assign intr_d     = override_on ? ctl_q[BIT_INTR] : intr_fn_in;
   assign sync_out_d = override_on ? ctl_q[BIT_SYNC_OUT] : sync_out_fn_in;
   // Undivided clock mode passes the clock straight through, override or not
   assign serial_out_clock_d   = (override_on && serial_out_clock_divided_in) ? ctl_q[BIT_SERIAL_OUT_CLOCK]
                                                          : serial_out_clock_fn_in;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
         logic sine_sel;
         logic second_fn_or_sine;
         assign sine_sel          = ctl_q[BIT_SINE_HI - ch];
         assign second_fn_or_sine = sine_sel ? carrier_sine_msb_in[ch]
                                             : second_serial_fn_in[ch];
         assign chan_sync_d[ch]     = override_on ? ctl_q[BIT_SYNC_HI - ch]
                                                  : chan_sync_fn_in[ch];
         assign first_serial_d[ch]  = override_on ? ctl_q[BIT_SD1_HI - ch]
                                                  : first_serial_fn_in[ch];
         assign second_serial_d[ch] = override_on ? ctl_q[BIT_SD2_HI - ch]
                                                  : second_fn_or_sine;
      end
   endgenerate

   // Read port: data stand only in the cycle after the strobe
   logic [DATA_W-1:0] rdata_d;

   assign rdata_d = !reg_rd_in   ? '0 :
                    sel_readback ? ctl_q :
                    sel_pn23     ? {{(DATA_W-PN23_W){1'b0}}, pn23_if.state} :
                    sel_pn15     ? {{(DATA_W-PN15_W){1'b0}}, pn15_if.state} :
                                   '0;

   // Output registers
   always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         reg_rdata_out          <= '0;
         intr_pin_out           <= 1'b0;
         sync_out_pin_out       <= 1'b0;
         serial_out_clock_out   <= 1'b0;
         chan_sync_pin_out      <= '0;
         first_serial_line_out  <= '0;
         second_serial_line_out <= '0;
         self_test_mode_out     <= 1'b0;
         dither_i_out           <= 1'b0;
         dither_q_out           <= 1'b0;
      end else begin
         reg_rdata_out          <= rdata_d;
         intr_pin_out           <= intr_d;
         sync_out_pin_out       <= sync_out_d;
         serial_out_clock_out   <= serial_out_clock_d;
         chan_sync_pin_out      <= chan_sync_d;
         first_serial_line_out  <= first_serial_d;
         second_serial_line_out <= second_serial_d;
         self_test_mode_out     <= test_mode;
         dither_i_out           <= dither_i_d;
         dither_q_out           <= dither_comb;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_sync_q);

   sequence s_ctl_write;
      reg_wr_in && sel_test_ctl;
   endsequence

   sequence s_override_armed;
      ctl_q[BIT_OVR_EN] && ctl_q[BIT_TEST_MODE];
   endsequence

   a_global_write_store: assert property (s_ctl_write |=> ctl_q == ($past(reg_wdata_in) & CTL_WRITE_MASK))
      else $error("global test control write not stored");
   a_foreign_write_ignored: assert property (reg_wr_in && !global_hit |=> $stable(ctl_q))
      else $error("write outside the global space changed test control");
   a_unused_bits_zero: assert property (ctl_q[15:10] == 6'h00)
      else $error("unused control bits are not zero");
   a_override_pins: assert property (s_override_armed |=>
      intr_pin_out == $past(ctl_q[BIT_INTR]) && sync_out_pin_out == $past(ctl_q[BIT_SYNC_OUT]) &&
      chan_sync_pin_out == 4'({<<{$past(ctl_q[BIT_SYNC_HI -: NUM_CH])}}) &&
      first_serial_line_out == 4'({<<{$past(ctl_q[BIT_SD1_HI -: NUM_CH])}}) &&
      second_serial_line_out == 4'({<<{$past(ctl_q[BIT_SD2_HI -: NUM_CH])}}))
      else $error("armed override did not drive control bits on the pins");
   a_override_needs_test: assert property (!ctl_q[BIT_TEST_MODE] |=>
      intr_pin_out == $past(intr_fn_in) && first_serial_line_out == $past(first_serial_fn_in))
      else $error("pin override acted without test mode");
   a_serial_out_clock_undivided: assert property (!serial_out_clock_divided_in |=>
      serial_out_clock_out == $past(serial_out_clock_fn_in))
      else $error("serial clock overridden in undivided mode");
   a_serial_out_clock_divided: assert property (s_override_armed and serial_out_clock_divided_in |=>
      serial_out_clock_out == $past(ctl_q[BIT_SERIAL_OUT_CLOCK]))
      else $error("serial clock not overridden in divided mode");
   a_sine_route_ch0: assert property (ctl_q[BIT_SINE_HI] && !override_on |=>
      second_serial_line_out[0] == $past(carrier_sine_msb_in[0]))
      else $error("channel zero sine MSB not routed to second serial line");
   a_sine_route_ch3: assert property (ctl_q[BIT_SINE_HI-3] && !override_on |=>
      second_serial_line_out[3] == $past(carrier_sine_msb_in[3]))
      else $error("channel three sine MSB not routed to second serial line");
   a_dither_q_combine: assert property (1'b1 |=> dither_q_out ==
      ($past(pn23_en & pn23_if.state[PN23_W-1]) ^ $past(pn15_en & pn15_if.state[PN15_W-1])))
      else $error("Q dither is not the xor of the enabled generators");
   a_dither_all_off: assert property ((!pn23_en && !pn15_en) [*2] |-> !dither_q_out && !dither_i_out)
      else $error("dither present with both generators disabled");
   a_i_offset_on: assert property (i_offset_en |=>
      (dither_i_out ^ dither_q_out) == $past(pn23_en & pn23_if.state[PN23_I_BIT]))
      else $error("I dither not decorrelated with generator bit 10");
   a_i_equals_q: assert property (!i_offset_en |=> dither_i_out == dither_q_out)
      else $error("I and Q dither differ with offset clear");
   a_test_mode_out: assert property (s_ctl_write ##1 1'b1 |=>
      self_test_mode_out == $past(reg_wdata_in[BIT_TEST_MODE], 2))
      else $error("self test output does not follow control bit 0");
   a_read_one_cycle: assert property (reg_rd_in && sel_readback |=> reg_rdata_out == $past(ctl_q)
      ##1 ($past(reg_rd_in) || reg_rdata_out == '0)[*1])
      else $error("read data wrong or not held for exactly one cycle");
   a_idle_read_zero: assert property (!reg_rd_in |=> reg_rdata_out == '0)
      else $error("read data nonzero without a read strobe");
   a_pn15_hold: assert property (!pn15_en |=> $stable(pn15_if.state))
      else $error("disabled 15-stage generator advanced");
endmodule
`default_nettype wire

// File: gtc_pin_tester.sv
// Board interconnect tester that gathers the pins in override-word order
`timescale 1ns/1ps
`default_nettype none
module gtc_pin_tester
   import gtc_pkg::*;
(
   input  wire logic              intr_in,
   input  wire logic              sync_out_in,
   input  wire logic              serial_out_clock_in,
   input  wire logic [NUM_CH-1:0] sync_in,
   input  wire logic [NUM_CH-1:0] first_in,
   input  wire logic [NUM_CH-1:0] second_in,
   output logic      [14:0]       pins_out
);
   // Channel A lands on the highest bit of each group
   assign pins_out = {intr_in, sync_out_in, serial_out_clock_in,
                      sync_in[0], sync_in[1], sync_in[2], sync_in[3],
                      first_in[0], first_in[1], first_in[2], first_in[3],
                      second_in[0], second_in[1], second_in[2], second_in[3]};
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the test-control and dither block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import gtc_pkg::*;
;
   logic              clk_sys_in;
   logic              rst_n_in;
   logic [ADDR_W-1:0] reg_addr_in;
   logic [DATA_W-1:0] reg_wdata_in;
   logic              reg_wr_in;
   logic              reg_rd_in;
   logic [DATA_W-1:0] reg_rdata_out;
   logic              serial_out_clock_div;
   logic              intr_fn;
   logic [NUM_CH-1:0] sine;
   logic [NUM_CH-1:0] sync_o, first_o, second_o;
   logic              intr_o, sync_out_o, serial_out_clock_o, self_test, dith_i, dith_q;
   logic [14:0]       pins;
   logic [31:0]       d0, d1;
   int                miscompares, total_checks, diff, ones;
   int                k;
   logic [31:0]       pat [3] = '{32'h5555_0001, 32'hAAAB_0001, 32'hFFFF_0001};

   gtc_test_ctrl dut (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .serial_out_clock_divided_in(serial_out_clock_div),
      .intr_fn_in(intr_fn), .sync_out_fn_in(1'b1), .serial_out_clock_fn_in(1'b0),
      .chan_sync_fn_in(4'h5), .first_serial_fn_in(4'hA), .second_serial_fn_in(4'h3),
      .carrier_sine_msb_in(sine), .intr_pin_out(intr_o), .sync_out_pin_out(sync_out_o),
      .serial_out_clock_out(serial_out_clock_o), .chan_sync_pin_out(sync_o),
      .first_serial_line_out(first_o), .second_serial_line_out(second_o),
      .self_test_mode_out(self_test), .dither_i_out(dith_i), .dither_q_out(dith_q));

   gtc_pin_tester tester (
      .intr_in(intr_o), .sync_out_in(sync_out_o), .serial_out_clock_in(serial_out_clock_o), .sync_in(sync_o),
      .first_in(first_o), .second_in(second_o), .pins_out(pins));

   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1;
   endtask

   // Two back-to-back reads of one address; the second sees one more clock
   task automatic rd2(input logic [15:0] a, output logic [31:0] r0, output logic [31:0] r1);
      @(posedge clk_sys_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      #1 r0 = reg_rdata_out;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 r1 = reg_rdata_out;
   endtask

   task automatic watch(input int n);
      diff = 0;
      ones = 0;
      repeat (n) begin
         @(posedge clk_sys_in);
         #1;
         if (dith_i !== dith_q) diff++;
         if (dith_q === 1'b1) ones++;
      end
   endtask

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(25 * 4000);
      miscompares++;
      end_sim();
   end

   initial begin
      miscompares = 0;
      total_checks = 0;
      rst_n_in = 1'b0;
      reg_addr_in = '0;
      reg_wdata_in = '0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      serial_out_clock_div = 1'b0;
      intr_fn = 1'b0;
      sine = 4'hC;
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      #1;
      chk(32'(pins), 32'h2A5C);
      chk(32'(self_test), 32'h0);
      rd2(ADDR_TEST_CTL, d0, d1);
      chk(d0, 32'h0);
      wr(16'h7800, 32'h0000_0001);
      chk(32'(self_test), 32'h0);
      wr(ADDR_TEST_CTL, 32'h0000_FC01);
      chk(32'(self_test), 32'h1);
      rd2(ADDR_CTL_READBACK, d0, d1);
      chk(d0, 32'h0000_0001);
      chk(d1, 32'h0000_0001);
      @(posedge clk_sys_in);
      #1 chk(reg_rdata_out, 32'h0);
      wr(ADDR_TEST_CTL, 32'h5555_0000);
      chk(32'(pins), 32'h2A5C);
      @(posedge clk_sys_in);
      intr_fn <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk(32'(pins), 32'h6A5C);
      for (k = 0; k < 3; k++) begin
         wr(ADDR_TEST_CTL, pat[k]);
         chk(32'(pins), 32'(pat[k][31:17] & 15'h6FFF));
         @(posedge clk_sys_in);
         serial_out_clock_div <= 1'b1;
         repeat (2) @(posedge clk_sys_in);
         #1;
         chk(32'(pins), 32'(pat[k][31:17]));
         @(posedge clk_sys_in);
         serial_out_clock_div <= 1'b0;
      end
      wr(ADDR_TEST_CTL, 32'h0000_0080);
      chk(32'(second_o), 32'h2);
      @(posedge clk_sys_in);
      sine <= 4'hD;
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk(32'(second_o), 32'h3);
      wr(ADDR_TEST_CTL, 32'h0000_0010);
      chk(32'(second_o), 32'hB);
      wr(ADDR_TEST_CTL, 32'h0000_0000);
      watch(64);
      chk(32'(ones), 32'h0);
      wr(ADDR_TEST_CTL, 32'h0000_0006);
      watch(64);
      chk(32'(diff), 32'h0);
      chk(32'(ones != 0), 32'h1);
      wr(ADDR_TEST_CTL, 32'h0000_000E);
      watch(64);
      chk(32'(diff != 0), 32'h1);
      wr(ADDR_TEST_CTL, 32'h0000_0004);
      rd2(ADDR_PN23_STAT, d0, d1);
      chk(32'(d0[22:0] != 0), 32'h1);
      chk(32'(d1[22:0]), 32'({d0[21:0], d0[22] ^ d0[17]}));
      rd2(ADDR_PN15_STAT, d0, d1);
      chk(d1, d0);
      wr(ADDR_TEST_CTL, 32'h0000_0002);
      watch(32);
      chk(32'(ones != 0), 32'h1);
      rd2(ADDR_PN15_STAT, d0, d1);
      chk(32'(d1[14:0]), 32'({d0[13:0], d0[14] ^ d0[13]}));
      rd2(ADDR_PN23_STAT, d0, d1);
      chk(d1, d0);
      rd2(16'hF8FF, d0, d1);
      chk(d0, 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
